// ==== eil_pkg.sv ====
// Contract
// R01 - falling pin edge sets interrupt latch
// R02 - vector fetch acknowledge clears the latch
// R03 - writing ack one clears latch, reads zero
// R04 - reset clears latch and mode bit
// R05 - edge mode: acknowledge clears latch immediately
// R06 - level mode: clear needs ack and pin high
// R07 - falling edge after ack latches again
// R08 - mode bit read/write, one adds level
// R09 - mask bit blocks request to priority logic
// R10 - pending flag readable regardless of mask
// R11 - serviced request uses vector FFFA/FFFB
// R12 - pin synchronised through two flip-flops
// R13 - eight-bit control register, upper bits zero
package eil_pkg;
    localparam logic [11:0] EIL_ADDR_ISC = 12'h000;
    localparam logic [11:0] EIL_ADDR_EVT_STAT = 12'h004;
    localparam logic [11:0] EIL_ADDR_EVT_MASK = 12'h008;
    localparam int EIL_BIT_MODE = 0;
    localparam int EIL_BIT_MASK = 1;
    localparam int EIL_BIT_ACK = 2;
    localparam int EIL_BIT_PEND = 3;
    localparam int EIL_EVT_LATCH = 0;
    localparam int EIL_EVT_CLEAR = 1;
    localparam int EIL_NUM_EVT = 2;
    localparam logic [15:0] EIL_VECTOR_HI = 16'hFFFA;
    localparam logic [15:0] EIL_VECTOR_LO = 16'hFFFB;
    localparam logic [1:0] EIL_RESP_OKAY = 2'h0;
    localparam logic [1:0] EIL_RESP_SLVERR = 2'h2;
    localparam logic EIL_SYNC_RESET = 1'h1;

    typedef struct packed {
        logic mode;
        logic mask;
    } eil_ctrl_s;

    typedef struct packed {
        logic [15:0] vec_addr;
        logic req;
    } eil_cpu_s;
endpackage

// ==== eil_sync.sv ====
`timescale 1ns/1ps
module eil_sync #(
    parameter logic RESET_VAL = 1'h1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic d,
    output logic q
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    always_comb begin
        meta_d = d;
        sync_d = meta_q;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign q = sync_q;
endmodule

// ==== eil_core.sv ====
`timescale 1ns/1ps
module eil_core (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin_s,
    input wire logic mode,
    input wire logic ack,
    output logic latch,
    output logic set_evt,
    output logic clr_evt
);
    logic pin_prev_q;
    logic pin_prev_d;
    logic latch_q;
    logic latch_d;
    logic ack_seen_q;
    logic ack_seen_d;
    logic [2:0] warm_q;
    logic [2:0] warm_d;
    logic fall;

    always_comb begin
        // edges are ignored until the synchroniser has flushed its reset value,
        // so a pin held low through reset does not latch a false request
        fall = warm_q[2] && pin_prev_q && !pin_s; // R04
        warm_d = {warm_q[1:0], 1'b1};
        pin_prev_d = pin_s;
        latch_d = latch_q;
        ack_seen_d = ack_seen_q;
        set_evt = 1'b0;
        clr_evt = 1'b0;
        if (latch_q) begin
            if (!mode) begin
                if (ack) begin
                    latch_d = 1'b0; // R05
                    clr_evt = 1'b1;
                end
            end else begin
                if (ack) begin
                    ack_seen_d = 1'b1;
                end
                if ((ack || ack_seen_q) && pin_s) begin
                    latch_d = 1'b0; // R06
                    ack_seen_d = 1'b0;
                    clr_evt = 1'b1;
                end
            end
        end else begin
            ack_seen_d = 1'b0;
        end
        // fresh edge wins over a clear in the same cycle
        if (fall) begin
            latch_d = 1'b1; // R01 R07
            ack_seen_d = 1'b0;
            clr_evt = 1'b0;
            set_evt = !latch_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_prev_q <= 1'b1;
            latch_q <= 1'b0; // R04
            ack_seen_q <= 1'b0;
            warm_q <= 3'h0;
        end else begin
            pin_prev_q <= pin_prev_d;
            latch_q <= latch_d;
            ack_seen_q <= ack_seen_d;
            warm_q <= warm_d;
        end
    end

    assign latch = latch_q;
endmodule

// ==== eil_top.sv ====
`timescale 1ns/1ps
module eil_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ext_int_n,
    input wire logic vec_fetch_ack,
    output eil_pkg::eil_cpu_s cpu_req,
    output logic irq,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import eil_pkg::*;

    logic pin_s;
    logic latch;
    logic set_evt;
    logic clr_evt;
    logic sw_ack;
    logic ack;

    eil_ctrl_s ctrl_q, ctrl_d;
    logic [EIL_NUM_EVT-1:0] stat_q, stat_d;
    logic [EIL_NUM_EVT-1:0] emask_q, emask_d;
    logic [11:0] awaddr_q, awaddr_d;
    logic aw_have_q, aw_have_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic w_have_q, w_have_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic awready_q, awready_d;
    logic wready_q, wready_d;
    logic arready_q, arready_d;
    eil_cpu_s cpu_q, cpu_d;
    logic irq_q, irq_d;
    logic ack_pulse_q, ack_pulse_d;

    eil_sync #(
        .RESET_VAL(EIL_SYNC_RESET)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(ext_int_n),
        .q(pin_s) // R12
    );

    // software ack is registered so it lines up with the bus write handshake
    assign sw_ack = ack_pulse_q;
    assign ack = sw_ack || vec_fetch_ack; // R02 R03

    eil_core u_core (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_s(pin_s),
        .mode(ctrl_q.mode),
        .ack(ack),
        .latch(latch),
        .set_evt(set_evt),
        .clr_evt(clr_evt)
    );

    logic do_write;
    logic do_read;
    logic [EIL_NUM_EVT-1:0] evt;

    always_comb begin
        evt = '0;
        evt[EIL_EVT_LATCH] = set_evt;
        evt[EIL_EVT_CLEAR] = clr_evt;
        awaddr_d = awaddr_q;
        aw_have_d = aw_have_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        w_have_d = w_have_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        ctrl_d = ctrl_q;
        emask_d = emask_q;
        stat_d = stat_q;
        ack_pulse_d = 1'b0;

        if (s_axi_awvalid && awready_q) begin
            awaddr_d = s_axi_awaddr;
            aw_have_d = 1'b1;
        end
        if (s_axi_wvalid && wready_q) begin
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
            w_have_d = 1'b1;
        end
        do_write = aw_have_q && w_have_q && !bvalid_q;
        if (do_write) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = EIL_RESP_OKAY;
            case (awaddr_q)
                EIL_ADDR_ISC: begin
                    if (wstrb_q[0]) begin
                        ctrl_d.mode = wdata_q[EIL_BIT_MODE]; // R08
                        ctrl_d.mask = wdata_q[EIL_BIT_MASK]; // R09
                        ack_pulse_d = wdata_q[EIL_BIT_ACK]; // R03
                    end
                end
                EIL_ADDR_EVT_STAT: begin
                end
                EIL_ADDR_EVT_MASK: begin
                    if (wstrb_q[0]) begin
                        emask_d = wdata_q[EIL_NUM_EVT-1:0];
                    end
                end
                default: begin
                    bresp_d = EIL_RESP_SLVERR;
                end
            endcase
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end

        do_read = s_axi_arvalid && arready_q;
        if (do_read) begin
            rvalid_d = 1'b1;
            rresp_d = EIL_RESP_OKAY;
            rdata_d = '0; // R13
            case (s_axi_araddr)
                EIL_ADDR_ISC: begin
                    rdata_d[EIL_BIT_MODE] = ctrl_q.mode;
                    rdata_d[EIL_BIT_MASK] = ctrl_q.mask;
                    rdata_d[EIL_BIT_PEND] = latch; // R10
                end
                EIL_ADDR_EVT_STAT: begin
                    rdata_d[EIL_NUM_EVT-1:0] = stat_q;
                    stat_d = '0;
                end
                EIL_ADDR_EVT_MASK: begin
                    rdata_d[EIL_NUM_EVT-1:0] = emask_q;
                end
                default: begin
                    rresp_d = EIL_RESP_SLVERR;
                end
            endcase
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        // new events win over the read-clear
        stat_d = stat_d | evt;

        awready_d = !aw_have_d && !bvalid_d;
        wready_d = !w_have_d && !bvalid_d;
        arready_d = !rvalid_d && !do_read;

        cpu_d.req = latch && !ctrl_q.mask; // R09
        cpu_d.vec_addr = EIL_VECTOR_HI; // R11
        irq_d = |(stat_d & emask_d);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= '0; // R04
            stat_q <= '0;
            emask_q <= '0;
            awaddr_q <= '0;
            aw_have_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= EIL_RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= EIL_RESP_OKAY;
            rdata_q <= '0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            arready_q <= 1'b0;
            cpu_q <= '0;
            irq_q <= 1'b0;
            ack_pulse_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            stat_q <= stat_d;
            emask_q <= emask_d;
            awaddr_q <= awaddr_d;
            aw_have_q <= aw_have_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            w_have_q <= w_have_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            arready_q <= arready_d;
            cpu_q <= cpu_d;
            irq_q <= irq_d;
            ack_pulse_q <= ack_pulse_d;
        end
    end

    assign cpu_req = cpu_q;
    assign irq = irq_q;
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
endmodule

// ==== eil_top_monitor.sv ====
`timescale 1ns/1ps
module eil_top_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ext_int_n,
    input wire logic vec_fetch_ack,
    input wire eil_pkg::eil_cpu_s cpu_req,
    input wire logic irq,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata
);
    import eil_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_vec_const: assert property (cpu_req.req |-> cpu_req.vec_addr == EIL_VECTOR_HI)
        else $error("vector address wrong");
    a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !cpu_req.req && !irq)
        else $error("request left after reset");
    a_fetch_clears: assert property ((ext_int_n[*6] ##0 vec_fetch_ack) |-> ##[1:3] !cpu_req.req)
        else $error("fetch ack did not clear");
    a_req_holds: assert property (((!s_axi_bvalid && !vec_fetch_ack && !ext_int_n)[*6]
        ##0 cpu_req.req) |=> cpu_req.req)
        else $error("request dropped with pin low");
    a_req_has_cause: assert property ($rose(cpu_req.req) |-> !$past(ext_int_n, 3)
        || !$past(ext_int_n, 4) || !$past(ext_int_n, 5) || $past(s_axi_bvalid) || s_axi_bvalid)
        else $error("request without cause");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("no write response");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("no read response");
    a_read_zero_bits: assert property (s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0
        && !s_axi_rdata[2])
        else $error("unused bits not zero");
endmodule
bind eil_top eil_top_monitor i_eil_top_monitor (.aclk(aclk), .aresetn(aresetn),
    .ext_int_n(ext_int_n), .vec_fetch_ack(vec_fetch_ack), .cpu_req(cpu_req), .irq(irq),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata));

// ==== eil_pin_model.sv ====
`timescale 1ns/1ps
module eil_pin_model (
    input wire logic pull_low,
    output logic ext_int_n
);
    // released pin rests at its pull-up level
    assign ext_int_n = pull_low ? 1'b0 : 1'b1;
endmodule

// ==== eil_top_test.sv ====
`timescale 1ns/1ps
module eil_top_test;
    import eil_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic pin_low = 1'b0;
    logic fetch = 1'b0;
    logic ext_int_n, irq, awready, wready, bvalid, arready, rvalid;
    eil_cpu_s cpu_req;
    logic [11:0] awaddr = 12'h0;
    logic [11:0] araddr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int n_mismatch = 0;
    int cmp_count = 0;
    always #50 aclk = ~aclk;
    eil_pin_model i_eil_pin_model (.pull_low(pin_low), .ext_int_n(ext_int_n));
    eil_top i_eil_top (.aclk(aclk), .aresetn(aresetn), .ext_int_n(ext_int_n),
        .vec_fetch_ack(fetch), .cpu_req(cpu_req), .irq(irq), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic flag(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 50);
        bready <= 1'b0;
        flag(bvalid, 1'b1);
        chk({30'h0, bresp}, {30'h0, er});
        @(posedge aclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 50);
        rready <= 1'b0;
        flag(rvalid, 1'b1);
        chk(rdata, e);
        chk({30'h0, rresp}, {30'h0, er});
        @(posedge aclk);
    endtask
    task automatic pulse_fetch();
        fetch <= 1'b1;
        cyc(1);
        fetch <= 1'b0;
        cyc(3);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        cyc(5000);
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        cyc(20);
        aresetn <= 1'b1;
        cyc(2);
        rd(EIL_ADDR_ISC, 32'h0, EIL_RESP_OKAY);
        rd(EIL_ADDR_EVT_STAT, 32'h0, EIL_RESP_OKAY);
        rd(12'h00C, 32'h0, EIL_RESP_SLVERR);
        wr(12'h00C, 32'h3, EIL_RESP_SLVERR);
        wr(EIL_ADDR_EVT_MASK, 32'h3, EIL_RESP_OKAY);
        rd(EIL_ADDR_EVT_MASK, 32'h3, EIL_RESP_OKAY);
        wr(EIL_ADDR_ISC, 32'h7, EIL_RESP_OKAY);
        rd(EIL_ADDR_ISC, 32'h3, EIL_RESP_OKAY);
        wr(EIL_ADDR_ISC, 32'h0, EIL_RESP_OKAY);
        $display("test registers done");
        pin_low <= 1'b1;
        cyc(8);
        flag(cpu_req.req, 1'b1);
        flag(irq, 1'b1);
        chk({16'h0, cpu_req.vec_addr}, {16'h0, EIL_VECTOR_HI});
        rd(EIL_ADDR_ISC, 32'h8, EIL_RESP_OKAY);
        rd(EIL_ADDR_EVT_STAT, 32'h1, EIL_RESP_OKAY);
        cyc(2);
        flag(irq, 1'b0);
        pulse_fetch();
        flag(cpu_req.req, 1'b0);
        rd(EIL_ADDR_EVT_STAT, 32'h2, EIL_RESP_OKAY);
        pin_low <= 1'b0;
        cyc(4);
        $display("test edge mode done");
        wr(EIL_ADDR_ISC, 32'h2, EIL_RESP_OKAY);
        pin_low <= 1'b1;
        cyc(3);
        pin_low <= 1'b0;
        cyc(8);
        flag(cpu_req.req, 1'b0);
        rd(EIL_ADDR_ISC, 32'hA, EIL_RESP_OKAY);
        wr(EIL_ADDR_ISC, 32'h0, EIL_RESP_OKAY);
        cyc(3);
        flag(cpu_req.req, 1'b1);
        $display("test mask done");
        wr(EIL_ADDR_ISC, 32'h4, EIL_RESP_OKAY);
        cyc(3);
        flag(cpu_req.req, 1'b0);
        pin_low <= 1'b1;
        cyc(3);
        pin_low <= 1'b0;
        cyc(8);
        flag(cpu_req.req, 1'b1);
        pulse_fetch();
        flag(cpu_req.req, 1'b0);
        $display("test fresh edge done");
        wr(EIL_ADDR_ISC, 32'h1, EIL_RESP_OKAY);
        pin_low <= 1'b1;
        cyc(8);
        wr(EIL_ADDR_ISC, 32'h5, EIL_RESP_OKAY);
        cyc(4);
        flag(cpu_req.req, 1'b1);
        rd(EIL_ADDR_ISC, 32'h9, EIL_RESP_OKAY);
        pin_low <= 1'b0;
        cyc(8);
        flag(cpu_req.req, 1'b0);
        rd(EIL_ADDR_ISC, 32'h1, EIL_RESP_OKAY);
        $display("test level mode done");
        pin_low <= 1'b1;
        cyc(8);
        flag(cpu_req.req, 1'b1);
        aresetn <= 1'b0;
        cyc(3);
        flag(cpu_req.req, 1'b0);
        aresetn <= 1'b1;
        cyc(4);
        flag(cpu_req.req, 1'b0);
        rd(EIL_ADDR_ISC, 32'h0, EIL_RESP_OKAY);
        pin_low <= 1'b0;
        $display("test reset done");
        report_and_stop();
    end
endmodule
